/* File: rtl/imasr_pkg.sv */
package imasr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int GROUPS      = 8;
  localparam int INT_REGS    = 4;
  localparam int APB_ADDR_W  = 16;
  localparam int APB_DATA_W  = 32;
  localparam int REG_W       = 16;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_TX_RATE_INT0  = 14'h0404;
  localparam logic [13:0] IDX_GRP_OVF_EN    = 14'h040b;
  localparam logic [13:0] IDX_RX_FIFO_OVF_EN = 14'h040c;
  localparam logic [13:0] IDX_GEN_STATUS_EN = 14'h040d;
  localparam logic [13:0] IDX_GEN_STATUS    = 14'h040e;
  localparam logic [13:0] IDX_CTR_XFER_CMD  = 14'h040f;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_TX_RATE_INT   = 16'h0c0c;
  localparam logic [15:0] RST_GRP_OVF_EN    = 16'h0000;
  localparam logic [15:0] RST_RX_FIFO_OVF_EN = 16'h0000;
  localparam logic [15:0] RST_GEN_STATUS_EN = 16'h0000;
  localparam logic [15:0] RST_GEN_STATUS    = 16'h0000;
  localparam logic [15:0] RST_CTR_XFER_CMD  = 16'h0080;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TRI_LO_POS      = 0;
  localparam int TRI_HI_POS      = 8;
  localparam int GS_OUT_CLK_BIT  = 3;
  localparam int GS_IN_CLK_BIT   = 2;
  localparam int GS_TX_FIFO_BIT  = 1;
  localparam int GS_CELL_MEM_BIT = 0;
  localparam int GS_BITS         = 4;
  localparam int CTC_RSVD11      = 11;
  localparam int CTC_LATCH_NOW   = 10;
  localparam int CTC_MODE_LO     = 8;
  localparam int CTC_DONE        = 7;
  localparam int CTC_TOGGLE      = 6;
  localparam int CTC_RSVD4       = 4;
  localparam int CTC_EN_VAL      = 3;
  localparam int CTC_DIR         = 2;
  localparam int CTC_CMD_LO      = 0;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_CLEAR_ALL = 2'h0;
  localparam logic [1:0] CMD_VALUE     = 2'h1;
  localparam logic [1:0] CMD_ENABLE    = 2'h2;
  localparam logic [1:0] CMD_UNUSED    = 2'h3;
  localparam logic [1:0] LATCH_OFF     = 2'h0;
  localparam logic [1:0] LATCH_EACH    = 2'h1;
  localparam logic [1:0] LATCH_DIV     = 2'h2;
  localparam logic [1:0] LATCH_SW      = 2'h3;
  localparam logic [3:0] PERIOD_CODE_RSVD = 4'hf;
  localparam logic [3:0] PERIOD_CODE_MAX  = 4'he;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PERIOD_BASE_LOG2     = 8;
  localparam int LATCH_DIV_EDGES      = 8000;
  localparam int CLK_PERIOD_PS        = 4000;
  localparam int CELL_CLK_TIMEOUT_NS  = 1000;
  localparam int CELL_CLK_TIMEOUT_CYC =
    (CELL_CLK_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic {
    XFER_IDLE,
    XFER_BUSY
  } imasr_xfer_state_t;

endpackage

/* File: rtl/imasr_period_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module imasr_period_timer
  import imasr_pkg::*;
#(
  parameter int BASE_LOG2 = PERIOD_BASE_LOG2
) (
  input  wire logic       ref_clk_in,   // device clock
  input  wire logic       rst_n_in,     // sync reset, active low
  input  wire logic       clk_en_in,    // freezes state while low
  input  wire logic [3:0] code_in,      // integration period code
  output logic            tick_out      // pulse at end of each period
);

  localparam int CNT_W = BASE_LOG2 + 14;

  if (BASE_LOG2 < 1 || BASE_LOG2 > 16) begin : g_chk
    $error("imasr_period_timer: BASE_LOG2 out of range");
  end

  logic [CNT_W-1:0] count;
  logic [3:0]       eff_code;
  logic [5:0]       shift_amt;
  logic [CNT_W-1:0] last_val;
  logic             at_end;

  // reserved code runs at the longest period
  assign eff_code  = (code_in == PERIOD_CODE_RSVD) ? PERIOD_CODE_MAX
                                                   : code_in;
  assign shift_amt = 6'(BASE_LOG2) + {2'h0, eff_code};
  assign last_val  = ~({CNT_W{1'b1}} << shift_amt);
  // a shortened period after a code change ends at once
  assign at_end    = (count >= last_val);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else if (clk_en_in) begin
      count    <= at_end ? '0 : count + 1'b1;
      tick_out <= at_end;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/imasr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module imasr_regs
  import imasr_pkg::*;
#(
  parameter int PERIOD_BASE = PERIOD_BASE_LOG2,
  parameter int CLK_TIMEOUT = CELL_CLK_TIMEOUT_CYC,
  parameter int LATCH_EDGES = LATCH_DIV_EDGES
) (
  input  wire logic                  ref_clk_in,        // 250 MHz clock
  input  wire logic                  rst_n_in,          // sync, active low
  input  wire logic                  clk_en_in,         // state frozen low
  input  wire logic                  psel_in,           // apb select
  input  wire logic                  penable_in,        // apb enable
  input  wire logic                  pwrite_in,         // apb direction
  input  wire logic [APB_ADDR_W-1:0] paddr_in,          // apb byte address
  input  wire logic [APB_DATA_W-1:0] pwdata_in,         // apb write data
  output logic      [APB_DATA_W-1:0] prdata_out,        // apb read data
  output logic                       pready_out,        // apb ready
  output logic                       pslverr_out,       // unmapped access
  input  wire logic [GROUPS-1:0]     grp_ovf_status_in, // group ovf status
  input  wire logic [GROUPS-1:0]     rx_fifo_ovf_in,    // rx fifo ovf status
  input  wire logic [GROUPS-1:0]     tx_fifo_ovf_in,    // tx fifo ovf events
  input  wire logic                  cell_mem_full_in,  // no free tx cell
  input  wire logic                  cell_out_clk_in,   // cell out clk pin
  input  wire logic                  cell_in_clk_in,    // cell in clk pin
  input  wire logic                  latch_clk_in,      // latch clock pin
  input  wire logic                  ctr_xfer_done_in,  // transfer finished
  output logic                       irq_out,           // interrupt request
  output logic      [GROUPS-1:0]     int_tick_out,      // period ends
  output logic                       ctr_xfer_req_out,  // transfer request
  output logic      [1:0]            ctr_xfer_cmd_out,  // transfer command
  output logic                       ctr_xfer_dir_out,  // transfer direction
  output logic                       ctr_xfer_en_out,   // enable value
  output logic                       ctr_latch_out      // latch counters
);

  if (CLK_TIMEOUT < 2 || CLK_TIMEOUT > 65535 ||
      LATCH_EDGES < 1 || LATCH_EDGES > 65535) begin : g_chk
    $error("imasr_regs: timeout or latch divider out of range");
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [13:0] idx;
  logic        aligned;
  logic [3:0]  hit_int;
  logic        hit_grp_en;
  logic        hit_rx_en;
  logic        hit_gs_en;
  logic        hit_gs;
  logic        hit_ctc;
  logic        mapped;
  logic        setup;
  logic        access;
  logic        wr;
  logic [15:0] wdata;

  assign idx        = paddr_in[15:2];
  assign aligned    = (paddr_in[1:0] == 2'h0);
  assign hit_grp_en = aligned && (idx == IDX_GRP_OVF_EN);
  assign hit_rx_en  = aligned && (idx == IDX_RX_FIFO_OVF_EN);
  assign hit_gs_en  = aligned && (idx == IDX_GEN_STATUS_EN);
  assign hit_gs     = aligned && (idx == IDX_GEN_STATUS);
  assign hit_ctc    = aligned && (idx == IDX_CTR_XFER_CMD);
  assign mapped     = (|hit_int) || hit_grp_en || hit_rx_en ||
                      hit_gs_en || hit_gs || hit_ctc;
  assign setup      = psel_in && !penable_in;
  assign access     = psel_in && penable_in;
  assign wr         = access && pwrite_in && mapped && clk_en_in;
  assign wdata      = pwdata_in[15:0];
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !mapped;

  // ----------------------------------------------------------------
  // integration period codes
  // ----------------------------------------------------------------
  logic [3:0]  period_code [GROUPS];
  logic [15:0] int_rd      [INT_REGS];

  for (genvar k = 0; k < INT_REGS; k++) begin : g_int
    assign hit_int[k] = aligned && (idx == IDX_TX_RATE_INT0 + 14'(k));
    assign int_rd[k]  = {4'h0, period_code[k + INT_REGS],
                         4'h0, period_code[k]};
  end

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    localparam int REG = g % INT_REGS;
    localparam int POS = (g < INT_REGS) ? TRI_LO_POS : TRI_HI_POS;

    always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
        period_code[g] <= RST_TX_RATE_INT[POS +: 4];
      end else if (wr && hit_int[REG]) begin
        period_code[g] <= wdata[POS +: 4];
      end
    end

    imasr_period_timer #(
      .BASE_LOG2 (PERIOD_BASE)
    ) u_timer (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .clk_en_in  (clk_en_in),
      .code_in    (period_code[g]),
      .tick_out   (int_tick_out[g])
    );
  end

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  logic [GROUPS-1:0]  grp_en;
  logic [GROUPS-1:0]  rx_en;
  logic [GS_BITS-1:0] gs_en;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      grp_en <= RST_GRP_OVF_EN[GROUPS-1:0];
      rx_en  <= RST_RX_FIFO_OVF_EN[GROUPS-1:0];
      gs_en  <= RST_GEN_STATUS_EN[GS_BITS-1:0];
    end else if (wr) begin
      if (hit_grp_en) grp_en <= wdata[GROUPS-1:0];
      if (hit_rx_en)  rx_en  <= wdata[GROUPS-1:0];
      if (hit_gs_en)  gs_en  <= wdata[GS_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // cell interface clock monitors
  // ----------------------------------------------------------------
  logic [1:0] clk_pin;
  logic [1:0] clk_fault;

  assign clk_pin = {cell_out_clk_in, cell_in_clk_in};

  for (genvar c = 0; c < 2; c++) begin : g_mon
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic [15:0] idle_cnt;

    always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
        sync1    <= 1'b0;
        sync2    <= 1'b0;
        sync3    <= 1'b0;
        idle_cnt <= '0;
      end else if (clk_en_in) begin
        sync1 <= clk_pin[c];
        sync2 <= sync1;
        sync3 <= sync2;
        if (sync2 && !sync3) begin
          idle_cnt <= '0;
        end else if (idle_cnt != 16'(CLK_TIMEOUT)) begin
          idle_cnt <= idle_cnt + 16'h0001;
        end
      end
    end

    // no rising edge within the timeout: missing or too slow
    assign clk_fault[c] = (idle_cnt == 16'(CLK_TIMEOUT));
  end

  // ----------------------------------------------------------------
  // general status
  // ----------------------------------------------------------------
  logic [GS_BITS-1:0] gen_status;
  logic [GS_BITS-1:0] gs_set;
  logic [GS_BITS-1:0] gs_clr;
  logic [GS_BITS-1:0] next_gen_status;

  assign gs_set[GS_OUT_CLK_BIT]  = clk_fault[1];
  assign gs_set[GS_IN_CLK_BIT]   = clk_fault[0];
  assign gs_set[GS_TX_FIFO_BIT]  = |tx_fifo_ovf_in;
  assign gs_set[GS_CELL_MEM_BIT] = cell_mem_full_in;
  // only written zeros clear; set beats a clear in the same cycle
  assign gs_clr = (wr && hit_gs) ? ~wdata[GS_BITS-1:0]
                                 : '0;
  assign next_gen_status = (gen_status & ~gs_clr) | gs_set;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      gen_status <= RST_GEN_STATUS[GS_BITS-1:0];
    end else if (clk_en_in) begin
      gen_status <= next_gen_status;
    end
  end

  // ----------------------------------------------------------------
  // counter transfer command
  // ----------------------------------------------------------------
  imasr_xfer_state_t xfer_state;
  logic              rsvd11;
  logic              latch_now;
  logic [1:0]        latch_mode;
  logic              toggle;
  logic              rsvd4;
  logic              en_val;
  logic              xfer_dir;
  logic [1:0]        xfer_cmd;
  logic              ctc_wr;
  logic [1:0]        w_mode;
  logic [1:0]        w_cmd;
  logic              sw_latch;
  logic              start_xfer;
  logic              xfer_done;
  logic [15:0]       ctc_rd;

  assign ctc_wr     = wr && hit_ctc;
  assign w_mode     = wdata[CTC_MODE_LO +: 2];
  assign w_cmd      = wdata[CTC_CMD_LO +: 2];
  assign sw_latch   = ctc_wr && wdata[CTC_LATCH_NOW] && !latch_now &&
                      (w_mode == LATCH_SW);
  assign start_xfer = ctc_wr && (xfer_state == XFER_IDLE) &&
                      (w_cmd != CMD_UNUSED);
  assign xfer_done  = (xfer_state == XFER_IDLE);
  assign ctc_rd     = {4'h0, rsvd11, latch_now, latch_mode, xfer_done,
                       toggle, 1'b0, rsvd4, en_val, xfer_dir, xfer_cmd};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rsvd11     <= RST_CTR_XFER_CMD[CTC_RSVD11];
      latch_now  <= RST_CTR_XFER_CMD[CTC_LATCH_NOW];
      latch_mode <= RST_CTR_XFER_CMD[CTC_MODE_LO +: 2];
      rsvd4      <= RST_CTR_XFER_CMD[CTC_RSVD4];
      en_val     <= RST_CTR_XFER_CMD[CTC_EN_VAL];
      xfer_dir   <= RST_CTR_XFER_CMD[CTC_DIR];
      xfer_cmd   <= RST_CTR_XFER_CMD[CTC_CMD_LO +: 2];
    end else if (ctc_wr) begin
      rsvd11     <= wdata[CTC_RSVD11];
      latch_now  <= wdata[CTC_LATCH_NOW];
      latch_mode <= w_mode;
      rsvd4      <= wdata[CTC_RSVD4];
      en_val     <= wdata[CTC_EN_VAL];
      xfer_dir   <= wdata[CTC_DIR];
      xfer_cmd   <= w_cmd;
    end
  end

  // toggles on every register write
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      toggle <= RST_CTR_XFER_CMD[CTC_TOGGLE];
    end else if (wr) begin
      toggle <= !toggle;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      xfer_state       <= XFER_IDLE;
      ctr_xfer_req_out <= 1'b0;
      ctr_xfer_cmd_out <= CMD_CLEAR_ALL;
      ctr_xfer_dir_out <= 1'b0;
      ctr_xfer_en_out  <= 1'b0;
    end else if (clk_en_in) begin
      ctr_xfer_req_out <= start_xfer;
      case (xfer_state)
        XFER_IDLE: begin
          if (start_xfer) begin
            xfer_state       <= XFER_BUSY;
            ctr_xfer_cmd_out <= w_cmd;
            ctr_xfer_dir_out <= wdata[CTC_DIR];
            ctr_xfer_en_out  <= wdata[CTC_EN_VAL];
          end
        end
        XFER_BUSY: begin
          if (ctr_xfer_done_in) begin
            xfer_state <= XFER_IDLE;
          end
        end
        default: begin
          xfer_state <= XFER_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // counter latch timing
  // ----------------------------------------------------------------
  logic        lclk_s1;
  logic        lclk_s2;
  logic        lclk_s3;
  logic        lclk_rise;
  logic [15:0] lclk_cnt;
  logic        lclk_wrap;
  logic        latch_pulse;

  assign lclk_rise   = lclk_s2 && !lclk_s3;
  assign lclk_wrap   = (lclk_cnt == 16'(LATCH_EDGES - 1));
  assign latch_pulse = sw_latch ||
                       (lclk_rise && (latch_mode == LATCH_EACH)) ||
                       (lclk_rise && (latch_mode == LATCH_DIV) &&
                        lclk_wrap);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      lclk_s1       <= 1'b0;
      lclk_s2       <= 1'b0;
      lclk_s3       <= 1'b0;
      lclk_cnt      <= '0;
      ctr_latch_out <= 1'b0;
    end else if (clk_en_in) begin
      lclk_s1       <= latch_clk_in;
      lclk_s2       <= lclk_s1;
      lclk_s3       <= lclk_s2;
      ctr_latch_out <= latch_pulse;
      if (latch_mode != LATCH_DIV) begin
        lclk_cnt <= '0;
      end else if (lclk_rise) begin
        lclk_cnt <= lclk_wrap ? '0 : lclk_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and interrupt
  // ----------------------------------------------------------------
  logic [15:0] rd_int;
  logic [15:0] rd_val;
  logic        irq_any;

  assign rd_int = hit_int[0] ? int_rd[0] :
                  hit_int[1] ? int_rd[1] :
                  hit_int[2] ? int_rd[2] :
                  hit_int[3] ? int_rd[3] : 16'h0000;
  assign rd_val = (|hit_int)  ? rd_int :
                  hit_grp_en  ? {8'h00, grp_en} :
                  hit_rx_en   ? {8'h00, rx_en} :
                  hit_gs_en   ? {12'h000, gs_en} :
                  hit_gs      ? {12'h000, gen_status} :
                  hit_ctc     ? ctc_rd : 16'h0000;
  assign irq_any = (|(grp_ovf_status_in & grp_en)) ||
                   (|(rx_fifo_ovf_in & rx_en)) ||
                   (|(gen_status & gs_en));

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= '0;
      irq_out    <= 1'b0;
    end else if (clk_en_in) begin
      if (setup && !pwrite_in) begin
        prdata_out <= {16'h0000, rd_val};
      end
      irq_out <= irq_any;
    end
  end

endmodule
`default_nettype wire

/* File: bench/imasr_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module imasr_monitor
  import imasr_pkg::*;
(
  input wire logic                  ref_clk_in,        // device clock
  input wire logic                  rst_n_in,          // sync reset
  input wire logic                  clk_en_in,         // clock enable
  input wire logic                  psel_in,           // apb select
  input wire logic                  penable_in,        // apb enable
  input wire logic                  pwrite_in,         // apb direction
  input wire logic [APB_ADDR_W-1:0] paddr_in,          // apb address
  input wire logic [APB_DATA_W-1:0] pwdata_in,         // apb write data
  input wire logic [APB_DATA_W-1:0] prdata_out,        // apb read data
  input wire logic                  pready_out,        // apb ready
  input wire logic                  pslverr_out,       // apb error
  input wire logic [GROUPS-1:0]     grp_ovf_status_in, // group status
  input wire logic [GROUPS-1:0]     rx_fifo_ovf_in,    // rx fifo status
  input wire logic                  irq_out,           // interrupt
  input wire logic [GROUPS-1:0]     int_tick_out,      // period ends
  input wire logic                  ctr_xfer_req_out,  // transfer request
  input wire logic [1:0]            ctr_xfer_cmd_out   // transfer command
);
  default clocking mon_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ------------------------------------------------------------------
  // shadow copies of the group and rx fifo interrupt enables
  // ------------------------------------------------------------------
  logic [GROUPS-1:0] grp_en;
  logic [GROUPS-1:0] rx_en;
  wire               wr_acc = psel_in & penable_in & pwrite_in & clk_en_in;
  wire               ctc_wr = wr_acc && paddr_in == {IDX_CTR_XFER_CMD, 2'b00};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      grp_en <= 8'h00;
      rx_en  <= 8'h00;
    end else if (wr_acc && paddr_in == {IDX_GRP_OVF_EN, 2'b00}) begin
      grp_en <= pwdata_in[GROUPS-1:0];
    end else if (wr_acc && paddr_in == {IDX_RX_FIFO_OVF_EN, 2'b00}) begin
      rx_en <= pwdata_in[GROUPS-1:0];
    end
  end

  a_ready_high: assert property (pready_out)
    else $error("pready low");
  a_slverr_phase: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("slave error outside access phase");
  a_upper_zero: assert property (prdata_out[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_grp_irq: assert property (
    |(grp_ovf_status_in & grp_en) |=> irq_out)
    else $error("enabled group overflow gave no interrupt");
  a_rx_irq: assert property (
    |(rx_fifo_ovf_in & rx_en) |=> irq_out)
    else $error("enabled rx fifo overflow gave no interrupt");
  a_req_pulse: assert property (
    ctr_xfer_req_out |=> !ctr_xfer_req_out)
    else $error("transfer request longer than one cycle");
  a_req_cause: assert property (
    ctr_xfer_req_out |-> $past(ctc_wr) || $past(ctc_wr, 2))
    else $error("transfer request without command write");
  a_cmd_hold: assert property (
    !ctr_xfer_req_out |-> $stable(ctr_xfer_cmd_out))
    else $error("transfer command changed without request");
  a_tick_pulse: assert property (
    int_tick_out[0] |=> !int_tick_out[0])
    else $error("period tick longer than one cycle");
endmodule
`default_nettype wire

/* File: bench/test_ima_status_irq_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ima_status_irq_regs
  import imasr_pkg::*;
;
  typedef struct packed {
    logic [13:0] idx;
    logic [15:0] rst;
    logic [15:0] wr;
    logic [15:0] rd;
  } imasr_row_t;

  logic                  ref_clk_in = 1'b0;
  logic                  rst_n_in, psel_in, penable_in, pwrite_in;
  logic                  cell_mem_full_in, cell_out_clk_in, cell_in_clk_in;
  logic                  ctr_xfer_done_in, oc_run, ic_run, r0, r1;
  logic [APB_ADDR_W-1:0] paddr_in;
  logic [APB_DATA_W-1:0] pwdata_in, prdata_out, rdat;
  logic [GROUPS-1:0]     grp_ovf_status_in, rx_fifo_ovf_in, tx_fifo_ovf_in;
  logic [GROUPS-1:0]     int_tick_out;
  logic                  pready_out, pslverr_out, irq_out, ctr_xfer_req_out;
  logic                  ctr_xfer_dir_out, ctr_xfer_en_out, ctr_latch_out;
  logic [1:0]            ctr_xfer_cmd_out;
  int                    mismatches = 0;
  int                    n_compared = 0;
  imasr_row_t            rows [8] = '{
    '{IDX_TX_RATE_INT0, 16'h0c0c, 16'hfefe, 16'h0e0e},
    '{IDX_TX_RATE_INT0 + 14'h1, 16'h0c0c, 16'h0b0c, 16'h0b0c},
    '{IDX_GRP_OVF_EN, 16'h0000, 16'hffff, 16'h00ff},
    '{IDX_RX_FIFO_OVF_EN, 16'h0000, 16'hffff, 16'h00ff},
    '{IDX_GEN_STATUS_EN, 16'h0000, 16'hffff, 16'h000f},
    '{IDX_GEN_STATUS, 16'h0000, 16'hffff, 16'h0000},
    '{14'h0410, 16'h0000, 16'hffff, 16'h0000},
    '{IDX_CTR_XFER_CMD, 16'h0080, 16'h0000, 16'h0000}};

  imasr_regs #(.PERIOD_BASE(2), .CLK_TIMEOUT(20), .LATCH_EDGES(4))
    imasr_regs_i (
    .ref_clk_in, .rst_n_in, .clk_en_in(1'b1), .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .grp_ovf_status_in, .rx_fifo_ovf_in, .tx_fifo_ovf_in, .cell_mem_full_in,
    .cell_out_clk_in, .cell_in_clk_in, .latch_clk_in(1'b0), .ctr_xfer_done_in,
    .irq_out, .int_tick_out, .ctr_xfer_req_out, .ctr_xfer_cmd_out,
    .ctr_xfer_dir_out, .ctr_xfer_en_out, .ctr_latch_out);

  always #2 ref_clk_in = ~ref_clk_in;

  // cell interface clocks run unless a test stops them
  always @(posedge ref_clk_in) begin
    if (oc_run) cell_out_clk_in <= ~cell_out_clk_in;
    if (ic_run) cell_in_clk_in <= ~cell_in_clk_in;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [13:0] idx,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel_in   <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in  <= {idx, 2'b00};
    pwdata_in <= {16'h0000, d};
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    rdat = prdata_out;
    psel_in   <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic per(input int g, input int exp);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    #1;
    while (int_tick_out[g] !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1 n++;
    end while (int_tick_out[g] !== 1'b1 && n < 2000);
    check(n, exp);
    if (int_tick_out[g] !== 1'b1) summarize();
  endtask

  task automatic req_seen();
    #1 r0 = ctr_xfer_req_out;
    @(posedge ref_clk_in);
    #1 r1 = ctr_xfer_req_out;
  endtask

  task automatic irq_after(input logic exp);
    repeat (3) @(posedge ref_clk_in);
    #1 check(irq_out, {31'h0, exp});
    @(posedge ref_clk_in);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {rst_n_in, psel_in, penable_in, pwrite_in, cell_mem_full_in} = '0;
    {cell_out_clk_in, cell_in_clk_in, ctr_xfer_done_in} = '0;
    {oc_run, ic_run} = 2'b11;
    paddr_in = 16'h0000;
    pwdata_in = 32'h0;
    {grp_ovf_status_in, rx_fifo_ovf_in, tx_fifo_ovf_in} = '0;
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].idx, 16'h0000);
      check(rdat, {16'h0000, rows[i].rst});
    end
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, rows[i].idx, rows[i].wr);
      apb(1'b0, rows[i].idx, 16'h0000);
      check(rdat, {16'h0000, rows[i].rd});
    end
    $display("register table test done");
    @(posedge ref_clk_in);
    grp_ovf_status_in <= 8'h01;
    irq_after(1'b1);
    apb(1'b1, IDX_GRP_OVF_EN, 16'h00fe);
    irq_after(1'b0);
    grp_ovf_status_in <= 8'h00;
    rx_fifo_ovf_in <= 8'h80;
    irq_after(1'b1);
    apb(1'b1, IDX_RX_FIFO_OVF_EN, 16'h007f);
    irq_after(1'b0);
    rx_fifo_ovf_in <= 8'h00;
    $display("interrupt enable test done");
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_in);
      case (k)
        0: cell_mem_full_in <= 1'b1;
        1: tx_fifo_ovf_in <= 8'h20;
        2: ic_run <= 1'b0;
        default: oc_run <= 1'b0;
      endcase
      @(posedge ref_clk_in);
      cell_mem_full_in <= 1'b0;
      tx_fifo_ovf_in <= 8'h00;
      repeat (40) @(posedge ref_clk_in);
      {oc_run, ic_run} <= 2'b11;
      repeat (10) @(posedge ref_clk_in);
      irq_after(1'b1);
      apb(1'b1, IDX_GEN_STATUS, 16'h000f);
      apb(1'b0, IDX_GEN_STATUS, 16'h0000);
      check(rdat, 32'h1 << k);
      apb(1'b1, IDX_GEN_STATUS, 16'h0000);
      apb(1'b0, IDX_GEN_STATUS, 16'h0000);
      check(rdat, 32'h0);
      irq_after(1'b0);
    end
    $display("general status test done");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, IDX_CTR_XFER_CMD, {12'h000, 2'b11, c[1:0]});
      req_seen();
      check(r0 | r1, {31'h0, c != 3});
      check({ctr_xfer_dir_out, ctr_xfer_en_out, ctr_xfer_cmd_out},
            {2'b11, (c == 3) ? 2'h2 : c[1:0]});
      apb(1'b0, IDX_CTR_XFER_CMD, 16'h0000);
      check(rdat[7], c == 3);
      apb(1'b1, IDX_CTR_XFER_CMD, {12'h000, 2'b11, c[1:0]});
      req_seen();
      check(r0 | r1, 32'h0);
      @(posedge ref_clk_in);
      ctr_xfer_done_in <= 1'b1;
      @(posedge ref_clk_in);
      ctr_xfer_done_in <= 1'b0;
      apb(1'b0, IDX_CTR_XFER_CMD, 16'h0000);
      check(rdat[7], 32'h1);
    end
    apb(1'b1, IDX_CTR_XFER_CMD, 16'h0703);
    #1 check(ctr_latch_out, 32'h1);
    apb(1'b1, IDX_CTR_XFER_CMD, 16'h0703);
    #1 check(ctr_latch_out, 32'h0);
    $display("counter transfer test done");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, IDX_TX_RATE_INT0, {4'h0, 4'(c + 1), 4'h0, 4'(c)});
      per(0, 1 << (2 + c));
      per(4, 2 << (2 + c));
    end
    $display("integration period test done");
    summarize();
  end
endmodule

bind imasr_regs imasr_monitor imasr_monitor_i (
  .ref_clk_in, .rst_n_in, .clk_en_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .grp_ovf_status_in, .rx_fifo_ovf_in, .irq_out, .int_tick_out,
  .ctr_xfer_req_out, .ctr_xfer_cmd_out);
`default_nettype wire
